// ### design/reset_source_pkg.sv
package reset_source_pkg;
    // apb register offsets (byte addresses)
    localparam logic [11:0] ctrl_offset = 12'h000;
    localparam logic [11:0] status_offset = 12'h004;
    localparam logic [11:0] cpu_offset = 12'h008;
    localparam logic [11:0] pll_offset = 12'h00c;
    localparam logic [11:0] frame_base = 12'h100;
    localparam logic [11:0] frame_last = 12'h1fc;
    localparam logic [11:0] frame_impl_last = 12'h13c;
    // control register fields
    localparam int keep_bit_pos = 14;
    localparam int fire_bit_pos = 15;
    localparam logic [15:0] ctrl_reset_value = 16'h4000;
    // cause status fields
    localparam int power_flag_pos = 13;
    localparam int bad_access_pos = 12;
    localparam int software_pos = 10;
    localparam int dog_pos = 9;
    // cpu state word fields
    localparam int ovf_pos = 0;
    localparam int flag_out_pos = 1;
    localparam int sign_ext_pos = 2;
    localparam int shift_mode_pos = 3;
    localparam int carry_pos = 4;
    localparam int ram_map_pos = 5;
    localparam int irq_disable_pos = 6;
    localparam int pc_clear_pos = 7;
    localparam logic [7:0] cpu_reset_value = 8'hd6;
    localparam logic [15:0] pll_reset_value = 16'h0000;
    localparam logic [15:0] pin_dir_reset_value = 16'h0000;
    localparam logic [15:0] wait_state_max = 16'h0007;
    // reset pin stretch
    localparam int stretch_cycles = 8;
    localparam logic [3:0] stretch_count = 4'(stretch_cycles);
endpackage

// ### design/reset_source_controller.sv
// Functional notes
// - watchdog overflow or bad key causes reset
// - keep bit cleared or fire bit set resets
// - reserved frame access causes reset
// - drive reset pin low eight cycles
// - stay in reset while pin held low
// - separate power, address, software, watchdog flags
// - cause flags survive every reset
// - ram kept, control bits initialised
// - program counter cleared to zero
// - only power-on clears pll bits
// - ram map bit cleared on reset
// - irq disable set, pending and mask cleared
// - status bits loaded with fixed values
// - repeat count, alloc cleared; wait max
// - accumulator and pointers left untouched
// - power-on high tristates pins, resets pll
// - pins and pll hold while power-on low
// - reset pin outputs internal resets
// - reset outranks every interrupt
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module reset_source_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dog_overflow,
    input wire logic dog_bad_key,
    input wire logic ext_reset_n_in,
    output logic ext_reset_n_out,
    output logic ext_reset_n_oe,
    input wire logic power_on_pin_n,
    output logic core_reset,
    output logic pc_clear,
    output logic irq_block,
    output logic [15:0] irq_pending_reg,
    output logic [15:0] irq_mask_reg,
    output logic [15:0] repeat_count,
    output logic [15:0] global_mem_alloc,
    output logic [15:0] wait_states,
    output logic [15:0] pll_ctrl,
    output logic io_tristate
);

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic setup_or_access = psel;
    wire logic access = psel & penable;
    wire logic wr = access & pwrite;
    wire logic setup_phase = setup_or_access & ~penable;
    wire logic hit_ctrl = paddr == reset_source_pkg::ctrl_offset;
    wire logic hit_status = paddr == reset_source_pkg::status_offset;
    wire logic hit_cpu = paddr == reset_source_pkg::cpu_offset;
    wire logic hit_pll = paddr == reset_source_pkg::pll_offset;
    wire logic in_frame = paddr >= reset_source_pkg::frame_base
        && paddr <= reset_source_pkg::frame_last;
    wire logic frame_reserved = in_frame && paddr > reset_source_pkg::frame_impl_last;
    wire logic hit_any = hit_ctrl | hit_status | hit_cpu | hit_pll | (in_frame & ~frame_reserved);

    logic [15:0] ctrl;
    logic [15:0] cause_status_reg;
    logic [7:0] status_word_one;
    logic [3:0] stretch;
    logic reset_active;
    logic power_on_level;

    // a write of the control word is what software sees as a reset request
    wire logic [15:0] ctrl_wdata = pwdata[15:0];
    wire logic ctrl_wr = wr & hit_ctrl & ~reset_active;
    wire logic soft_req = ctrl_wr & (~ctrl_wdata[reset_source_pkg::keep_bit_pos]
        | ctrl_wdata[reset_source_pkg::fire_bit_pos]);
    wire logic bad_req = access & frame_reserved;
    wire logic dog_req = dog_overflow | dog_bad_key;
    wire logic pin_low = ~ext_reset_n_in;
    wire logic power_low = ~power_on_pin_n;
    wire logic internal_req = soft_req | bad_req | dog_req;
    wire logic any_req = internal_req | pin_low | power_low;
    // causes the device itself puts on the pin; the pin level is left out to avoid self-hold
    wire logic drive_req = internal_req | power_low;

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: single access cycle, error on unmapped or reserved address
    // both answers are loaded at the setup edge so they stand through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~hit_any;
        end
    end

    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_ctrl) begin
            next_prdata = {16'h0000, ctrl};
        end else if (hit_status) begin
            next_prdata = {16'h0000, cause_status_reg};
        end else if (hit_cpu) begin
            next_prdata = {24'h00_0000, status_word_one};
        end else if (hit_pll) begin
            next_prdata = {16'h0000, pll_ctrl};
        end
    end
    // read data registered in the setup cycle so it stands at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_or_access & ~penable & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stretch counter: reload on any request, held while pin or power-on low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretch <= reset_source_pkg::stretch_count;
        end else if (any_req) begin
            stretch <= reset_source_pkg::stretch_count;
        end else if (stretch != 4'h0) begin
            stretch <= stretch - 4'h1;
        end
    end
    // the pin drive counts internal causes and power-on low only, so the pin input is not self-latched
    logic [3:0] drive_count;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_count <= reset_source_pkg::stretch_count;
        end else if (drive_req) begin
            drive_count <= reset_source_pkg::stretch_count;
        end else if (drive_count != 4'h0) begin
            drive_count <= drive_count - 4'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_reset_n_oe <= 1'b1;
            reset_active <= 1'b1;
        end else begin
            ext_reset_n_oe <= drive_req | (drive_count > 4'h1);
            reset_active <= any_req | (stretch > 4'h1);
        end
    end
    assign ext_reset_n_out = 1'b0; // open drain: only ever pulls low
    assign core_reset = reset_active;
    assign pc_clear = status_word_one[reset_source_pkg::pc_clear_pos];
    assign irq_block = status_word_one[reset_source_pkg::irq_disable_pos];

    ////////////////////////////////////////////////////////////////////////////
    // sticky cause flags: never touched by presetn, set wins over a clear in the same cycle
    logic power_cause_flag;
    logic bad_access_flag;
    logic software_cause_flag;
    logic dog_cause_flag;
    wire logic status_wr = wr & hit_status;
    always_ff @(posedge pclk) begin
        if (power_low) begin
            power_cause_flag <= 1'b1;
        end else if (status_wr & pwdata[reset_source_pkg::power_flag_pos]) begin
            power_cause_flag <= 1'b0;
        end
    end
    always_ff @(posedge pclk) begin
        if (bad_req) begin
            bad_access_flag <= 1'b1;
        end else if (status_wr & pwdata[reset_source_pkg::bad_access_pos]) begin
            bad_access_flag <= 1'b0;
        end
    end
    always_ff @(posedge pclk) begin
        if (soft_req) begin
            software_cause_flag <= 1'b1;
        end else if (status_wr & pwdata[reset_source_pkg::software_pos]) begin
            software_cause_flag <= 1'b0;
        end
    end
    always_ff @(posedge pclk) begin
        if (dog_req) begin
            dog_cause_flag <= 1'b1;
        end else if (status_wr & pwdata[reset_source_pkg::dog_pos]) begin
            dog_cause_flag <= 1'b0;
        end
    end
    // status word built from the flags, unused bits read zero; flags sticky across resets
    always_comb begin
        cause_status_reg = 16'h0000;
        cause_status_reg[reset_source_pkg::power_flag_pos] = power_cause_flag;
        cause_status_reg[reset_source_pkg::bad_access_pos] = bad_access_flag;
        cause_status_reg[reset_source_pkg::software_pos] = software_cause_flag;
        cause_status_reg[reset_source_pkg::dog_pos] = dog_cause_flag;
    end

    ////////////////////////////////////////////////////////////////////////////
    // control word: back to keep-set state during any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= reset_source_pkg::ctrl_reset_value;
        end else if (reset_active | any_req) begin
            ctrl <= reset_source_pkg::ctrl_reset_value;
        end else if (ctrl_wr) begin
            ctrl <= ctrl_wdata;
        end
    end

    // cpu state loaded while in reset; no ram, accumulator or pointers here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_word_one <= reset_source_pkg::cpu_reset_value;
            irq_pending_reg <= 16'h0000;
            irq_mask_reg <= 16'h0000;
            repeat_count <= 16'h0000;
            global_mem_alloc <= 16'h0000;
            wait_states <= reset_source_pkg::wait_state_max;
        end else if (reset_active) begin
            status_word_one <= reset_source_pkg::cpu_reset_value;
            irq_pending_reg <= 16'h0000;
            irq_mask_reg <= 16'h0000;
            repeat_count <= 16'h0000;
            global_mem_alloc <= 16'h0000;
            wait_states <= reset_source_pkg::wait_state_max;
        end else begin
            status_word_one[reset_source_pkg::pc_clear_pos] <= 1'b0;
            if (wr & hit_cpu) begin
                status_word_one[6:0] <= pwdata[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-on level domain: pll and pin state are reset only by presetn and the power-on pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_on_level <= 1'b1; // idle level, so leaving presetn is no rising edge
        end else begin
            power_on_level <= power_on_pin_n;
        end
    end
    wire logic power_rise = power_on_pin_n & ~power_on_level;
    // hold while low load reset values on the rising level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_ctrl <= reset_source_pkg::pll_reset_value;
            io_tristate <= 1'b1;
        end else if (power_rise) begin
            pll_ctrl <= reset_source_pkg::pll_reset_value;
            io_tristate <= 1'b1;
        end else if (!power_low) begin
            if (wr & hit_pll & ~reset_active) begin
                pll_ctrl <= pwdata[15:0];
            end
            if (!reset_active && wr && hit_ctrl) begin
                io_tristate <= 1'b0; // software releases pins after reset
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    // pin-drive cycles since the last cause that reloaded the stretch
    logic [3:0] low_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_run <= 4'h0;
        end else if (drive_req) begin
            low_run <= 4'h0;
        end else if (ext_reset_n_oe) begin
            low_run <= (low_run == 4'hf) ? low_run : low_run + 4'h1;
        end else begin
            low_run <= 4'h0;
        end
    end

    property p_dog_reset;
        @(posedge pclk) disable iff (!presetn) dog_req |=> core_reset;
    endproperty
    a_dog_reset: assert property (p_dog_reset) else $error("watchdog did not reset");

    property p_soft_reset;
        @(posedge pclk) disable iff (!presetn) soft_req |=> core_reset && ext_reset_n_oe;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

    property p_bad_flag;
        @(posedge pclk) disable iff (!presetn)
            bad_req |=> cause_status_reg[reset_source_pkg::bad_access_pos] && core_reset;
    endproperty
    a_bad_flag: assert property (p_bad_flag) else $error("bad access not flagged");

    property p_stretch;
        @(posedge pclk) disable iff (!presetn)
            internal_req |=> ext_reset_n_oe [*8];
    endproperty
    a_stretch: assert property (p_stretch) else $error("pin pulse too short");

    property p_pulse_ends;
        @(posedge pclk) disable iff (!presetn) low_run <= 4'h8;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pin pulse ran on");

    property p_hold_pin;
        @(posedge pclk) disable iff (!presetn) pin_low |=> core_reset;
    endproperty
    a_hold_pin: assert property (p_hold_pin) else $error("left reset with pin low");

    property p_dog_sticky;
        @(posedge pclk) disable iff (!presetn)
            cause_status_reg[reset_source_pkg::dog_pos] && !(wr && hit_status)
            |=> cause_status_reg[reset_source_pkg::dog_pos];
    endproperty
    a_dog_sticky: assert property (p_dog_sticky) else $error("dog flag lost");

    property p_irq_cleared;
        @(posedge pclk) disable iff (!presetn)
            core_reset |=> irq_block && irq_mask_reg == 16'h0000 && irq_pending_reg == 16'h0000;
    endproperty
    a_irq_cleared: assert property (p_irq_cleared) else $error("irq state not reset");

    property p_pll_hold;
        @(posedge pclk) disable iff (!presetn) power_low |=> $stable(pll_ctrl);
    endproperty
    a_pll_hold: assert property (p_pll_hold) else $error("pll moved while power low");

    property p_pc_start;
        @(posedge pclk) disable iff (!presetn) $fell(core_reset) |-> pc_clear ##1 !pc_clear;
    endproperty
    a_pc_start: assert property (p_pc_start) else $error("pc clear not one cycle");

    property p_power_rise;
        @(posedge pclk) disable iff (!presetn)
            power_rise |=> pll_ctrl == reset_source_pkg::pll_reset_value && io_tristate;
    endproperty
    a_power_rise: assert property (p_power_rise) else $error("power rise did not reset");

    property p_cpu_init;
        @(posedge pclk) disable iff (!presetn)
            core_reset |=> status_word_one == reset_source_pkg::cpu_reset_value;
    endproperty
    a_cpu_init: assert property (p_cpu_init) else $error("status bits not loaded");

    property p_mem_init;
        @(posedge pclk) disable iff (!presetn) core_reset |=> repeat_count == 16'h0000
            && global_mem_alloc == 16'h0000 && wait_states == reset_source_pkg::wait_state_max;
    endproperty
    a_mem_init: assert property (p_mem_init) else $error("memory setup not reset");

    property p_drive_pin;
        @(posedge pclk) disable iff (!presetn) drive_req |=> ext_reset_n_oe;
    endproperty
    a_drive_pin: assert property (p_drive_pin) else $error("cause not driven on pin");

    property p_soft_flag;
        @(posedge pclk) disable iff (!presetn)
            soft_req |=> cause_status_reg[reset_source_pkg::software_pos];
    endproperty
    a_soft_flag: assert property (p_soft_flag) else $error("software cause not flagged");

    property p_power_flag;
        @(posedge pclk) disable iff (!presetn)
            power_low |=> cause_status_reg[reset_source_pkg::power_flag_pos];
    endproperty
    a_power_flag: assert property (p_power_flag) else $error("power cause not flagged");

    property p_bus_answer;
        @(posedge pclk) disable iff (!presetn) psel && penable |-> pready;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("access cycle not answered");

    c_soft: cover property (@(posedge pclk) disable iff (!presetn) soft_req);
    c_dog: cover property (@(posedge pclk) disable iff (!presetn) dog_req ##1 core_reset);
    c_power: cover property (@(posedge pclk) disable iff (!presetn) power_rise);
    c_pin_hold: cover property (@(posedge pclk) disable iff (!presetn)
        pin_low && !ext_reset_n_oe);
    c_bad: cover property (@(posedge pclk) disable iff (!presetn) bad_req);

endmodule

// ### sim/board_reset.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// board side of the reset pin: pull-up resistor, a push button and a supply monitor
module board_reset (
    input wire logic pclk,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic hold_req,
    input wire logic por_req,
    output logic pin_level,
    output logic power_on_pin_n
);
    logic hold_low;

    initial begin
        power_on_pin_n = 1'b1;
        hold_low = 1'b0;
    end
    // open-drain line, pulled up when nobody sinks it
    assign pin_level = (dev_oe ? dev_out : 1'b1) & !hold_low;
    // registered requests, so every low pulse lasts whole clock cycles
    always @(posedge pclk) begin
        power_on_pin_n <= !por_req;
        // pin is let go one cycle after the power-on level rises, never before it
        hold_low <= hold_req | por_req | !power_on_pin_n;
    end
endmodule

// ### sim/reset_source_controller_tb.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module reset_source_controller_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dog_overflow = 1'b0;
    logic dog_bad_key = 1'b0;
    logic hold_req = 1'b0;
    logic por_req = 1'b0;
    logic pin_level, ext_out, ext_oe, power_on_pin_n, core_reset, pc_clear, irq_block;
    logic [15:0] irq_pending_reg, irq_mask_reg, repeat_count, global_mem_alloc;
    logic [15:0] wait_states, pll_ctrl;
    logic io_tristate, er, pc;
    logic [31:0] rd;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    logic [31:0] sw [2] = '{32'h0000c000, 32'h00000000};

    always #2.5 pclk = ~pclk;

    reset_source_controller dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dog_overflow(dog_overflow), .dog_bad_key(dog_bad_key),
        .ext_reset_n_in(pin_level), .ext_reset_n_out(ext_out), .ext_reset_n_oe(ext_oe),
        .power_on_pin_n(power_on_pin_n), .core_reset(core_reset), .pc_clear(pc_clear),
        .irq_block(irq_block), .irq_pending_reg(irq_pending_reg), .irq_mask_reg(irq_mask_reg),
        .repeat_count(repeat_count), .global_mem_alloc(global_mem_alloc),
        .wait_states(wait_states), .pll_ctrl(pll_ctrl), .io_tristate(io_tristate));

    board_reset board (.pclk(pclk), .dev_out(ext_out), .dev_oe(ext_oe), .hold_req(hold_req),
        .por_req(por_req), .pin_level(pin_level), .power_on_pin_n(power_on_pin_n));

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // counts pin-drive cycles until the core runs again; pcs is set when pc clear
    // stands in the first running cycle only
    task automatic run_wait(output int cyc, output logic pcs);
        #1;
        cyc = (ext_oe === 1'b1);
        for (int i = 0; i < 300 && core_reset !== 1'b0; i++) begin
            @(posedge pclk);
            #1;
            if (ext_oe === 1'b1 && core_reset === 1'b1)
                cyc++;
        end
        chk("core running", 32'h0, {31'h0, core_reset});
        pcs = (pc_clear === 1'b1);
        @(posedge pclk);
        #1;
        pcs = pcs && (pc_clear === 1'b0);
    endtask

    task automatic status_is(input logic [31:0] exp);
        xfer(reset_source_pkg::status_offset, 1'b0, 32'h0);
        chk("cause flags", exp, rd & 32'h00003600);
    endtask

    // control state every reset must restore
    task automatic check_init();
        chk("pending", 32'h0, {16'h0, irq_pending_reg});
        chk("mask", 32'h0, {16'h0, irq_mask_reg});
        chk("irq block", 32'h1, {31'h0, irq_block});
        chk("repeat", 32'h0, {16'h0, repeat_count});
        chk("alloc", 32'h0, {16'h0, global_mem_alloc});
        chk("waits", {16'h0, reset_source_pkg::wait_state_max}, {16'h0, wait_states});
        xfer(reset_source_pkg::cpu_offset, 1'b0, 32'h0);
        // reset status bits with the pc clear bit already back to zero
        chk("cpu state", 32'h00000056, rd);
        xfer(reset_source_pkg::ctrl_offset, 1'b0, 32'h0);
        chk("ctrl", 32'h00004000, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (8000) @(posedge pclk);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        run_wait(n, pc);
        chk("pc clear", 32'h1, {31'h0, pc});
        xfer(reset_source_pkg::status_offset, 1'b1, 32'h00003600);
        status_is(32'h0);
        xfer(reset_source_pkg::pll_offset, 1'b1, 32'h00001234);
        xfer(reset_source_pkg::ctrl_offset, 1'b1, 32'h00004000);
        #1;
        chk("io driven", 32'h0, {31'h0, io_tristate});
        // software reset by fire bit, then by dropping the keep bit
        for (int i = 0; i < 2; i++) begin
            xfer(reset_source_pkg::cpu_offset, 1'b1, 32'h00000021);
            xfer(reset_source_pkg::status_offset, 1'b1, 32'h00003600);
            xfer(reset_source_pkg::ctrl_offset, 1'b1, sw[i]);
            run_wait(n, pc);
            chk("stretch", 32'h1, {31'h0, n >= 8});
            chk("pc clear", 32'h1, {31'h0, pc});
            status_is(32'h00000400);
            check_init();
            xfer(reset_source_pkg::pll_offset, 1'b0, 32'h0);
            chk("pll kept", 32'h00001234, rd);
        end
        // both watchdog causes, one-cycle pulses
        for (int i = 0; i < 2; i++) begin
            xfer(reset_source_pkg::status_offset, 1'b1, 32'h00003600);
            @(posedge pclk);
            dog_overflow <= (i == 0);
            dog_bad_key <= (i == 1);
            @(posedge pclk);
            dog_overflow <= 1'b0;
            dog_bad_key <= 1'b0;
            run_wait(n, pc);
            chk("dog stretch", 32'h1, {31'h0, n >= 8});
            status_is(32'h00000200);
        end
        // reserved frame access, unmapped and implemented reads
        xfer(12'h140, 1'b0, 32'h0);
        chk("reserved err", 32'h1, {31'h0, er});
        run_wait(n, pc);
        status_is(32'h00001200);
        xfer(12'h010, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        xfer(reset_source_pkg::frame_base, 1'b0, 32'h0);
        chk("frame err", 32'h0, {31'h0, er});
        // board holds the pin well past the stretch
        @(posedge pclk);
        hold_req <= 1'b1;
        repeat (30) @(posedge pclk);
        #1;
        chk("held in reset", 32'h1, {31'h0, core_reset});
        @(posedge pclk);
        hold_req <= 1'b0;
        run_wait(n, pc);
        status_is(32'h00001200);
        // power-on pulse clears the pll and floats the pins
        @(posedge pclk);
        por_req <= 1'b1;
        repeat (3) @(posedge pclk);
        por_req <= 1'b0;
        run_wait(n, pc);
        chk("por stretch", 32'h1, {31'h0, n >= 8});
        chk("pll cleared", 32'h0, {16'h0, pll_ctrl});
        chk("io float", 32'h1, {31'h0, io_tristate});
        status_is(32'h00003200);
        // second reset in mid-run leaves the causes alone
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        run_wait(n, pc);
        status_is(32'h00003200);
        conclude();
    end
endmodule
